// file: sop_params.svh
// Timing constants and configuration encodings of the status output pin control.
`ifndef SOP_PARAMS_SVH
`define SOP_PARAMS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SOP_CLK_PERIOD_NS 4
`define SOP_FRAME_END_TO_LOW_NS 400
`define SOP_STOP_TO_LOW_NS 400
`define SOP_FRAME_START_TO_LOW_NS 400
`define SOP_FRAME_END_TO_RELEASE_NS 400
`define SOP_STOP_TO_RELEASE_NS 400
`define SOP_PULSE_NS 2000
`define SOP_FRAME_END_TO_LOW_CYC ((`SOP_FRAME_END_TO_LOW_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)
`define SOP_STOP_TO_LOW_CYC ((`SOP_STOP_TO_LOW_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)
`define SOP_FRAME_START_TO_LOW_CYC ((`SOP_FRAME_START_TO_LOW_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)
`define SOP_FRAME_END_TO_RELEASE_CYC ((`SOP_FRAME_END_TO_RELEASE_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)
`define SOP_STOP_TO_RELEASE_CYC ((`SOP_STOP_TO_RELEASE_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)
`define SOP_PULSE_CYC ((`SOP_PULSE_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)
// ----------------------------------------
// Configuration nibble values
// ----------------------------------------
`define SOP_CFG_RESET 8'h00
`define SOP_MODE_MSG 4'h3
`define SOP_MODE_PULSE 4'h4
`define SOP_MODE_STATE 4'h5
`define SOP_MODE_BUSY 4'h6
`define SOP_CNT_W 10
`endif

// file: sop_pkg.sv
// Types shared by the status output pin control.
package sop_pkg;
	// ----------------------------------------
	// Event strobes and levels
	// ----------------------------------------
	typedef struct packed {
		logic cl_frame_start;
		logic cl_frame_end;
		logic cl_select;
		logic cl_deselect;
		logic cl_field;
		logic cl_len_write;
		logic cl_int_cmd;
		logic cl_assert_cmd;
		logic cl_release_cmd;
		logic tw_stop;
		logic tw_session_req;
		logic tw_abort_cmd;
		logic tw_token_release;
		logic tw_int_cmd;
		logic tw_assert_cmd;
		logic tw_release_cmd;
		logic tw_first_byte_end;
		logic write_busy;
	} sop_events_t;
	typedef enum logic [1:0] {
		SOP_IDLE = 2'b00,
		SOP_WAIT = 2'b01,
		SOP_LOW = 2'b10
	} sop_phase_t;
	typedef struct packed {
		logic cl_session;
		logic tw_session;
		sop_phase_t phase;
		logic [9:0] cnt;
		logic from_tw;
		logic hold_low;
		logic msg_wait_write;
		logic pin_low;
		logic busy_rel;
		logic [9:0] rel_cnt;
		logic hold_req;
		logic [9:0] hold_cnt;
	} sop_state_t;
endpackage

// file: sop_ctrl.sv
// Status output pin control: sessions, modes and open-drain drive.
`include "sop_params.svh"
// Functional notes
// - Message mode: nonzero length write pulls low
// - Low after frame delay, through write
// - Pulse mode: interrupt command gives negative pulse
// - Pulse timing per contactless or two-wire source
// - State mode: assert command drives low
// - State low until release, power, contactless session close
// - Busy mode: low after first frame start
// - Busy low until contactless session end or field loss, no delay
// - Open-drain, released with no session open
// - Contactless session: select opens, deselect/abort/field close
// - Two-wire session: request/abort opens, token closes
module sop_ctrl (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] cfg,
	input wire sop_pkg::sop_events_t ev,
	input wire logic status_output_pin_in,
	output logic status_output_pin_out,
	output logic status_output_pin_oe
);
	localparam logic [9:0] FE_LOW = 10'(`SOP_FRAME_END_TO_LOW_CYC);
	localparam logic [9:0] STOP_LOW = 10'(`SOP_STOP_TO_LOW_CYC);
	localparam logic [9:0] FS_LOW = 10'(`SOP_FRAME_START_TO_LOW_CYC);
	localparam logic [9:0] FE_REL = 10'(`SOP_FRAME_END_TO_RELEASE_CYC);
	localparam logic [9:0] STOP_REL = 10'(`SOP_STOP_TO_RELEASE_CYC);
	localparam logic [9:0] PULSE = 10'(`SOP_PULSE_CYC);

	sop_pkg::sop_state_t s_reg, s_next;
	logic [3:0] cl_mode, tw_mode;
	logic pin_sync1_reg, pin_sync2_reg;

	assign cl_mode = cfg[7:4];
	assign tw_mode = cfg[3:0];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		if (ev.cl_select && ev.cl_field) begin
			s_next.cl_session = 1'b1;
		end else if (ev.cl_deselect || ev.tw_abort_cmd || !ev.cl_field) begin
			s_next.cl_session = 1'b0;
		end
		if (ev.tw_session_req || ev.tw_abort_cmd) begin
			s_next.tw_session = 1'b1;
		end else if (ev.tw_token_release) begin
			s_next.tw_session = 1'b0;
		end
		if (cl_mode == `SOP_MODE_MSG && s_reg.cl_session && ev.cl_len_write && s_reg.phase == sop_pkg::SOP_IDLE) begin
			s_next.phase = sop_pkg::SOP_WAIT;
			s_next.cnt = FE_LOW;
			s_next.msg_wait_write = 1'b1;
			s_next.from_tw = 1'b0;
		end
		if (s_reg.phase == sop_pkg::SOP_IDLE) begin
			if (cl_mode == `SOP_MODE_PULSE && s_reg.cl_session && ev.cl_int_cmd) begin
				s_next.phase = sop_pkg::SOP_WAIT;
				s_next.cnt = FE_LOW;
				s_next.from_tw = 1'b0;
			end else if (tw_mode == `SOP_MODE_PULSE && s_reg.tw_session && ev.tw_int_cmd) begin
				s_next.phase = sop_pkg::SOP_WAIT;
				s_next.cnt = STOP_LOW;
				s_next.from_tw = 1'b1;
			end
		end
		case (s_reg.phase)
			sop_pkg::SOP_WAIT: begin
				if (s_reg.cnt <= 10'h001) begin
					s_next.phase = sop_pkg::SOP_LOW;
					s_next.cnt = PULSE;
				end else begin
					s_next.cnt = s_reg.cnt - 10'h001;
				end
			end
			sop_pkg::SOP_LOW: begin
				if (s_reg.msg_wait_write) begin
					if (!ev.write_busy) begin
						s_next.phase = sop_pkg::SOP_IDLE;
						s_next.msg_wait_write = 1'b0;
					end
				end else if (s_reg.from_tw) begin
					if (ev.tw_first_byte_end) begin
						s_next.phase = sop_pkg::SOP_IDLE;
					end
				end else if (s_reg.cnt <= 10'h001) begin
					s_next.phase = sop_pkg::SOP_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 10'h001;
				end
			end
			default: begin
			end
		endcase
		// session close releases hold
		// Only the closing edge of the contactless session counts, so a two-wire hold survives on its own.
		if (s_reg.cl_session && !s_next.cl_session) begin
			s_next.hold_req = 1'b0;
			s_next.hold_low = 1'b0;
			s_next.hold_cnt = 10'h000;
		end else if (s_reg.hold_cnt > 10'h001) begin
			s_next.hold_cnt = s_reg.hold_cnt - 10'h001;
		end else if (s_reg.hold_cnt == 10'h001) begin
			s_next.hold_cnt = 10'h000;
			s_next.hold_low = s_reg.hold_req;
		end
		// release command after delay
		// A command only moves the request; the pin follows when the delay runs out.
		if (cl_mode == `SOP_MODE_STATE && s_reg.cl_session && ev.cl_release_cmd) begin
			s_next.hold_req = 1'b0;
			s_next.hold_cnt = FE_REL;
		end else if (tw_mode == `SOP_MODE_STATE && s_reg.tw_session && ev.tw_release_cmd) begin
			s_next.hold_req = 1'b0;
			s_next.hold_cnt = STOP_REL;
		end
		// assert command after delay
		// The assert is applied last, so it wins over a release or a close in the same cycle.
		if (cl_mode == `SOP_MODE_STATE && s_reg.cl_session && ev.cl_assert_cmd) begin
			s_next.hold_req = 1'b1;
			s_next.hold_cnt = FE_LOW;
		end else if (tw_mode == `SOP_MODE_STATE && s_reg.tw_session && ev.tw_assert_cmd) begin
			s_next.hold_req = 1'b1;
			s_next.hold_cnt = STOP_LOW;
		end
		// busy low from frame start to session end
		// Field loss also disarms; a frame start arms only with the field on, even before any session opens.
		if (s_reg.busy_rel && ((s_reg.cl_session && !s_next.cl_session) || !ev.cl_field)) begin
			s_next.busy_rel = 1'b0;
		end else if (s_reg.busy_rel && s_reg.rel_cnt != 10'h000) begin
			s_next.rel_cnt = s_reg.rel_cnt - 10'h001;
		end
		if (cl_mode == `SOP_MODE_BUSY && ev.cl_field && ev.cl_frame_start && !s_reg.busy_rel) begin
			s_next.busy_rel = 1'b1;
			s_next.rel_cnt = FS_LOW;
		end
		// drive only while a session is open
		s_next.pin_low = (s_reg.cl_session || s_reg.tw_session) &&
			(s_next.phase == sop_pkg::SOP_LOW || s_next.hold_low ||
			(cl_mode == `SOP_MODE_BUSY && s_next.busy_rel && s_next.rel_cnt == 10'h000));
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			pin_sync1_reg <= 1'b1;
			pin_sync2_reg <= 1'b1;
		end else begin
			s_reg <= s_next;
			pin_sync1_reg <= status_output_pin_in;
			pin_sync2_reg <= pin_sync1_reg;
		end
	end

	// ----------------------------------------
	// Open-drain pin
	// ----------------------------------------
	// The output value is always zero; only the enable moves, so the pin never drives high.
	assign status_output_pin_out = 1'b0;
	assign status_output_pin_oe = s_reg.pin_low;

	chk_idle_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
		(!$past(s_reg.cl_session) && !$past(s_reg.tw_session)) |-> !status_output_pin_oe)
		else $error("pin driven with no session");
	chk_tw_close: assert property (@(posedge mclk) disable iff (!rst_n)
		(ev.tw_token_release && !ev.tw_session_req && !ev.tw_abort_cmd) |=> !s_reg.tw_session)
		else $error("two-wire session stayed open");
	chk_field_close: assert property (@(posedge mclk) disable iff (!rst_n)
		!ev.cl_field |=> !s_reg.cl_session)
		else $error("contactless session stayed open");
	chk_assert_low: assert property (@(posedge mclk) disable iff (!rst_n)
		(tw_mode == `SOP_MODE_STATE && s_reg.tw_session && ev.tw_assert_cmd && !ev.cl_assert_cmd) |=>
		(s_reg.hold_req && s_reg.hold_cnt == STOP_LOW))
		else $error("assert command not held");
	chk_release_free: assert property (@(posedge mclk) disable iff (!rst_n)
		(tw_mode == `SOP_MODE_STATE && s_reg.tw_session && ev.tw_release_cmd && !ev.tw_assert_cmd && !ev.cl_assert_cmd &&
		!ev.cl_release_cmd) |=> (!s_reg.hold_req && s_reg.hold_cnt == STOP_REL))
		else $error("hold not released");
	chk_hold_delay: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(s_reg.hold_low) |-> $past(s_reg.hold_cnt) == 10'h001)
		else $error("state drive without delay");
	chk_pulse_len: assert property (@(posedge mclk) disable iff (!rst_n)
		($rose(s_reg.phase == sop_pkg::SOP_LOW) && !s_reg.from_tw && !s_reg.msg_wait_write)
		|-> (s_reg.phase == sop_pkg::SOP_LOW)[*8])
		else $error("pulse too short");
	chk_pulse_start: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_reg.phase == sop_pkg::SOP_IDLE && cl_mode == `SOP_MODE_PULSE && s_reg.cl_session && ev.cl_int_cmd)
		|=> s_reg.phase == sop_pkg::SOP_WAIT ##[1:200] s_reg.phase == sop_pkg::SOP_LOW)
		else $error("pulse did not start");
	chk_msg_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_reg.phase == sop_pkg::SOP_LOW && s_reg.msg_wait_write && ev.write_busy) |=> s_reg.phase == sop_pkg::SOP_LOW)
		else $error("message low ended during write");
	chk_busy_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(cl_mode == `SOP_MODE_BUSY && s_reg.busy_rel && s_reg.rel_cnt == 10'h000 && s_reg.cl_session &&
		ev.cl_field && !ev.cl_deselect && !ev.tw_abort_cmd) |=> status_output_pin_oe)
		else $error("busy low dropped in session");
	// driven pin reads back low
	// The pin is wired-and, so only the driven-low direction can be promised here.
	chk_pin_readback: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(status_output_pin_oe, 2) |-> !pin_sync2_reg)
		else $error("driven pin not read back low");
endmodule // sop_ctrl

// file: sop_host_model.sv
// Host input model that watches the open-drain status pin.
module sop_host_model (
	input wire logic pin_oe,
	input wire logic pin_out,
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up level
	// The pull-up gives a high level whenever the pin is released.
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule // sop_host_model

// file: tb_top.sv
// Self-checking testbench of the status output pin control.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] cfg = 8'h00;
	sop_pkg::sop_events_t ev = '0;
	logic pin_out;
	logic pin_oe;
	logic pin_level;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	sop_ctrl sop_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .ev(ev),
		.status_output_pin_in(pin_level), .status_output_pin_out(pin_out), .status_output_pin_oe(pin_oe));
	sop_host_model sop_host_model_inst (.pin_oe(pin_oe), .pin_out(pin_out), .pin_level(pin_level));
	initial begin
		forever #2 mclk = ~mclk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic fire(input logic [17:0] m);
		@(posedge mclk) ev <= ev | m;
		@(posedge mclk) ev <= ev & ~m;
	endtask
	task automatic chk(input logic exp, input int n);
		repeat (n) @(posedge mclk);
		#1;
		tests_run++;
		if ({pin_oe, pin_level} !== {exp, ~exp}) begin
			failures++;
			$display("Error t=%0t exp=%h got=%h", $time, {exp, ~exp}, {pin_oe, pin_level});
		end
	endtask
	task automatic field(input logic on, input logic [7:0] c);
		@(posedge mclk) begin
			ev.cl_field <= on;
			cfg <= c;
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_idle;
		field(1'b0, 8'h44);
		fire(18'h00810);
		chk(1'b0, 150);
		field(1'b1, 8'h04);
		fire(18'h08000);
		fire(18'h00800);
		chk(1'b0, 150);
		fire(18'h04000);
		fire(18'h00080);
		fire(18'h00020);
		fire(18'h00010);
		chk(1'b0, 150);
	endtask
	task automatic t_pulse;
		field(1'b1, 8'h44);
		fire(18'h08000);
		fire(18'h00800);
		chk(1'b0, 90);
		chk(1'b1, 25);
		chk(1'b1, 380);
		chk(1'b0, 120);
		fire(18'h00080);
		fire(18'h00010);
		chk(1'b1, 115);
		fire(18'h00002);
		chk(1'b0, 5);
		fire(18'h00020);
		fire(18'h04000);
	endtask
	// Two-wire and contactless set and release, then abort and field loss as session closers.
	task automatic t_state;
		field(1'b1, 8'h55);
		fire(18'h00080);
		fire(18'h00008);
		chk(1'b0, 90);
		chk(1'b1, 25);
		fire(18'h00004);
		chk(1'b1, 90);
		chk(1'b0, 25);
		fire(18'h00020);
		fire(18'h08000);
		fire(18'h00400);
		chk(1'b1, 115);
		fire(18'h00200);
		chk(1'b0, 115);
		fire(18'h00400);
		chk(1'b1, 115);
		fire(18'h00040);
		chk(1'b0, 5);
		fire(18'h00020);
		fire(18'h08000);
		fire(18'h00400);
		chk(1'b1, 115);
		field(1'b0, 8'h55);
		chk(1'b0, 5);
	endtask
	task automatic t_busy;
		field(1'b1, 8'h60);
		fire(18'h08000);
		fire(18'h20000);
		chk(1'b0, 90);
		chk(1'b1, 25);
		fire(18'h30000);
		chk(1'b1, 50);
		fire(18'h04000);
		chk(1'b0, 115);
		field(1'b0, 8'h60);
		fire(18'h20000);
		field(1'b1, 8'h60);
		fire(18'h08000);
		chk(1'b0, 115);
		fire(18'h04000);
	endtask
	task automatic t_msg;
		field(1'b1, 8'h30);
		fire(18'h08000);
		@(posedge mclk) ev.write_busy <= 1'b1;
		fire(18'h01000);
		chk(1'b0, 90);
		chk(1'b1, 25);
		chk(1'b1, 200);
		@(posedge mclk) ev.write_busy <= 1'b0;
		chk(1'b0, 115);
		fire(18'h04000);
	endtask
	// A reset in mid-run stands for power removal and must drop a held pin.
	task automatic t_power;
		field(1'b1, 8'h05);
		fire(18'h00080);
		fire(18'h00008);
		chk(1'b1, 115);
		@(posedge mclk) rst_n <= 1'b0;
		chk(1'b0, 2);
		@(posedge mclk) rst_n <= 1'b1;
		chk(1'b0, 115);
		fire(18'h00020);
	endtask
	// Cuts a hang short; the scenarios need about three thousand cycles.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			failures++;
			report_and_stop;
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		chk(1'b0, 1);
		t_idle;
		t_pulse;
		t_state;
		t_busy;
		t_msg;
		t_power;
		report_and_stop;
	end
endmodule // tb_top
